// >>> design/srb_sram_ctrl.sv
// location register and access control of the local single-cycle memory
`timescale 1ns/1ns
`include "srb_cfg.svh"

//////////////////////////////////////////////////////////////////////////////
// Function
// - the core only writes the register, with a control move to 0xC05.
// - the debug path can read and write the whole register.
// - undefined bits drop written data and read as zero on debug reads.
// - reset clears only the enable flag, all other fields keep value.
// - bits 31-16 place a 32-Kbyte window that an access must fall in.
// - two 16K banks, bit 11 sets upper-bank winner, bit 10 lower.
// - bit 9 blocks dma accesses when clear, allows them when set.
// - dma also needs the peripheral-side bank enable to get in.
// - with bit 8 set only reads are served, writes raise access error.
// - bits 5-1 each keep one address space out of the memory.
// - bit 0 enables the memory, when clear nothing is serviced.
module srb_sram_ctrl (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  // core control-register move
  input  wire logic                  ctlWrEn,
  input  wire logic [11:0]           ctlRegNum,
  input  wire logic [31:0]           ctlWrData,
  // debug module access
  input  wire logic                  dbgWrEn,
  input  wire logic [31:0]           dbgWrData,
  input  wire logic                  dbgRdEn,
  output logic      [31:0]           dbgRdData,
  output logic                       dbgRdValid,
  // core reference
  input  wire srb_pkg::srb_req_type  cpuRef,
  input  wire srb_pkg::srb_space_type cpuSpace,
  output logic                       cpuSel,
  output logic                       cpuStall,
  output logic                       cpuAccessErr,
  // dma reference
  input  wire srb_pkg::srb_req_type  dmaRef,
  input  wire logic                  peripheralBankEnable,
  output logic                       dmaSel,
  output logic                       dmaStall,
  output logic                       dmaAccessErr,
  // per-bank strobes to the arrays
  output logic [1:0]                 bankCpuGrant,
  output logic [1:0]                 bankDmaGrant
);

  //////////////////////////////////////////////////////////////////////////
  // location register

  srb_pkg::srb_loc_type locQ;
  srb_pkg::srb_loc_type locD;
  logic                 locValidQ;
  logic [30:0]          locFieldQ;
  logic [31:0]          locWord;
  logic                 coreWr;
  logic [31:0]          dbgRdDataD;

  // two flop groups, one with reset and one without, seen as one word
  assign locQ    = {locFieldQ, locValidQ};
  assign locWord = locQ;

  // debug write wins a same-cycle collision with a core move
  always_comb begin
    coreWr = ctlWrEn & (ctlRegNum == `SRB_CTL_REGNUM);
    locD   = locQ;
    if (dbgWrEn) begin
      locD = dbgWrData & `SRB_WR_MASK;
    end else if (coreWr) begin
      locD = ctlWrData & `SRB_WR_MASK;
    end
  end

  // only the enable flag sees reset, so a warm reset keeps the setup
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      locValidQ <= `SRB_VALID_RESET;
    end else begin
      locValidQ <= locD.valid;
    end
  end

  // no reset here on purpose
  always_ff @(posedge mclk) begin
    locFieldQ <= locD[31:1];
  end

  // debug read path, core moves cannot read
  always_comb begin
    dbgRdDataD = dbgRdEn ? (locWord & `SRB_WR_MASK) : dbgRdData;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dbgRdData  <= 32'h00000000;
      dbgRdValid <= 1'b0;
    end else begin
      dbgRdData  <= dbgRdDataD;
      dbgRdValid <= dbgRdEn;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // hit decode

  logic cpuInWin;
  logic dmaInWin;
  logic cpuMasked;
  logic cpuHit;
  logic dmaHit;
  logic cpuUpper;
  logic dmaUpper;

  // window is the low 32K of the 64K slot the base field names
  always_comb begin
    cpuInWin  = (cpuRef.addr[31:16] == locQ.baseAddr) &
                ~cpuRef.addr[`SRB_WIN_BIT];
    dmaInWin  = (dmaRef.addr[31:16] == locQ.baseAddr) &
                ~dmaRef.addr[`SRB_WIN_BIT];
    cpuMasked = locQ.spaceMask[cpuSpace];
    cpuHit    = cpuRef.req & locQ.valid & cpuInWin & ~cpuMasked;
    dmaHit    = dmaRef.req & locQ.valid & dmaInWin &
                locQ.secondaryPortEnable &
                peripheralBankEnable;
    cpuUpper  = cpuRef.addr[`SRB_BANK_BIT];
    dmaUpper  = dmaRef.addr[`SRB_BANK_BIT];
  end

  // protected writes never reach the array
  always_comb begin
    cpuAccessErr = cpuHit & cpuRef.write & locQ.writeProtect;
    dmaAccessErr = dmaHit & dmaRef.write & locQ.writeProtect;
  end

  //////////////////////////////////////////////////////////////////////////
  // bank arbitration

  logic [1:0] cpuWant;
  logic [1:0] dmaWant;
  logic [1:0] dmaFirst;

  always_comb begin
    dmaFirst = {locQ.upperBankPriority,
                locQ.lowerBankPriority};
  end

  genvar b;
  generate
    for (b = 0; b < `SRB_NUM_BANKS; b++) begin : g_bank
      assign cpuWant[b] = cpuHit & ~cpuAccessErr & (cpuUpper == 1'(b));
      assign dmaWant[b] = dmaHit & ~dmaAccessErr & (dmaUpper == 1'(b));
      srb_bank_arb u_arb (
        .cpuWant  (cpuWant[b]),
        .dmaWant  (dmaWant[b]),
        .dmaFirst (dmaFirst[b]),
        .cpuGrant (bankCpuGrant[b]),
        .dmaGrant (bankDmaGrant[b])
      );
    end
  endgenerate

  // a miss goes on as a normal bus reference, a hit that loses its bank stalls
  always_comb begin
    cpuSel   = |bankCpuGrant;
    dmaSel   = |bankDmaGrant;
    cpuStall = (|cpuWant) & ~cpuSel;
    dmaStall = (|dmaWant) & ~dmaSel;
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_core_write;
    coreWr && !dbgWrEn |=> locWord == ($past(ctlWrData) & `SRB_WR_MASK);
  endproperty
  a_core_write: assert property (p_core_write)
    else $error("core move did not load register");

  property p_other_num;
    !dbgWrEn && !coreWr |=> $stable(locWord);
  endproperty
  a_other_num: assert property (p_other_num)
    else $error("register changed without a write");

  property p_dbg_read;
    dbgRdEn |=> dbgRdValid &&
                dbgRdData == ($past(locWord) & `SRB_WR_MASK);
  endproperty
  a_dbg_read: assert property (p_dbg_read)
    else $error("debug read data wrong");

  property p_rsvd_zero;
    (dbgRdData & ~`SRB_WR_MASK) == 32'h00000000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits read nonzero");

  property p_reset;
    @(posedge mclk) disable iff (1'b0) !rst_b |-> !locQ.valid;
  endproperty
  a_reset: assert property (p_reset)
    else $error("valid not cleared in reset");

  property p_window;
    cpuSel |-> cpuRef.addr[31:16] == locQ.baseAddr && !cpuRef.addr[15];
  endproperty
  a_window: assert property (p_window)
    else $error("select outside window");

  property p_mask;
    cpuRef.req && locQ.spaceMask[cpuSpace] |-> !cpuSel && !cpuAccessErr;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked space reached memory");

  property p_invalid;
    !locQ.valid |-> !cpuSel && !dmaSel && !cpuAccessErr && !dmaAccessErr;
  endproperty
  a_invalid: assert property (p_invalid)
    else $error("disabled memory serviced access");

  property p_dma_gate;
    dmaSel |-> locQ.secondaryPortEnable && peripheralBankEnable;
  endproperty
  a_dma_gate: assert property (p_dma_gate)
    else $error("dma got in while blocked");

  property p_wp;
    cpuRef.req && cpuRef.write && cpuHit && locQ.writeProtect
      |-> cpuAccessErr && !cpuSel;
  endproperty
  a_wp: assert property (p_wp)
    else $error("protected write not refused");

  property p_pri_upper;
    cpuWant[1] && dmaWant[1]
      |-> bankDmaGrant[1] == locQ.upperBankPriority &&
          cpuStall == locQ.upperBankPriority;
  endproperty
  a_pri_upper: assert property (p_pri_upper)
    else $error("upper bank winner wrong");

  property p_pri_lower;
    cpuWant[0] && dmaWant[0]
      |-> bankCpuGrant[0] == !locQ.lowerBankPriority;
  endproperty
  a_pri_lower: assert property (p_pri_lower)
    else $error("lower bank winner wrong");

  c_setup_hit: cover property (coreWr ##1 locQ.valid ##[1:8] cpuSel);
  c_contend: cover property (cpuWant[1] && dmaWant[1]);
  c_wp_err: cover property (cpuAccessErr);
  c_dbg_read: cover property (dbgWrEn ##[1:4] dbgRdEn ##1 dbgRdValid);

endmodule : srb_sram_ctrl

// >>> design/srb_cfg.svh
// constants of the local-memory location register
`ifndef SRB_CFG_SVH
`define SRB_CFG_SVH
`define SRB_CTL_REGNUM   12'hC05
`define SRB_WR_MASK      32'hFFFF0F3F
`define SRB_VALID_RESET  1'b0
`define SRB_BASE_MSB     31
`define SRB_BASE_LSB     16
`define SRB_WIN_BIT      15
`define SRB_BANK_BIT     14
`define SRB_UPPER_BANK   1
`define SRB_LOWER_BANK   0
`define SRB_NUM_BANKS    2
`endif

// >>> design/srb_pkg.sv
// types shared by the local-memory location logic
package srb_pkg;

  // field layout of the location register, bit 31 first
  typedef struct packed {
    logic [15:0] baseAddr;
    logic [3:0]  rsvdHigh;
    logic        upperBankPriority;
    logic        lowerBankPriority;
    logic        secondaryPortEnable;
    logic        writeProtect;
    logic [1:0]  rsvdLow;
    logic [4:0]  spaceMask;
    logic        valid;
  } srb_loc_type;

  // address space of a core reference, value is its mask bit index
  typedef enum logic [2:0] {
    SPACE_USER_DATA  = 3'h0,
    SPACE_USER_CODE  = 3'h1,
    SPACE_SUPER_DATA = 3'h2,
    SPACE_SUPER_CODE = 3'h3,
    SPACE_CPU_IACK   = 3'h4
  } srb_space_type;

  // one reference from a bus master
  typedef struct packed {
    logic        req;
    logic        write;
    logic [31:0] addr;
  } srb_req_type;

endpackage : srb_pkg

// >>> design/srb_bank_arb.sv
// two-master arbiter for one memory bank
`timescale 1ns/1ns
module srb_bank_arb (
  // requests
  input  wire logic cpuWant,
  input  wire logic dmaWant,
  // configured winner, high gives the bank to dma
  input  wire logic dmaFirst,
  // grants
  output logic      cpuGrant,
  output logic      dmaGrant
);

  // fixed priority, loser waits a cycle and retries
  always_comb begin
    cpuGrant = cpuWant & (~dmaWant | ~dmaFirst);
    dmaGrant = dmaWant & (~cpuWant | dmaFirst);
  end

endmodule : srb_bank_arb

// >>> testbench/srb_dma_model.sv
// dma master model that presents one reference to the block
`timescale 1ns/1ns
module srb_dma_model (
  // request from the tests
  input  wire logic            go,
  input  wire logic            wr,
  input  wire logic [31:0]     addr,
  // reference towards the block
  output srb_pkg::srb_req_type dmaRef
);
  // idle shows the inverted address, so a stale value never looks valid
  always_comb dmaRef = go ? {1'b1, wr, addr} : {1'b0, 1'b0, ~addr};
endmodule : srb_dma_model

// >>> testbench/tb.sv
// self-checking bench of the memory location register block
`timescale 1ns/1ns
module tb;
  logic mclk, rst_b, ctlWrEn, dbgWrEn, dbgRdEn, peripheralBankEnable;
  logic dGo, dWr, dbgRdValid, cpuSel, cpuStall, cpuAccessErr;
  logic dmaSel, dmaStall, dmaAccessErr;
  logic [11:0] ctlRegNum;
  logic [31:0] ctlWrData, dbgWrData, dbgRdData, dAddr;
  logic [1:0] bankCpuGrant, bankDmaGrant;
  srb_pkg::srb_req_type cpuRef, dmaRef;
  srb_pkg::srb_space_type cpuSpace;
  int errorCnt, checkCount;

  srb_sram_ctrl i_srb_sram_ctrl (.mclk, .rst_b, .ctlWrEn, .ctlRegNum,
    .ctlWrData, .dbgWrEn, .dbgWrData, .dbgRdEn, .dbgRdData, .dbgRdValid,
    .cpuRef, .cpuSpace, .cpuSel, .cpuStall, .cpuAccessErr, .dmaRef,
    .peripheralBankEnable, .dmaSel, .dmaStall, .dmaAccessErr,
    .bankCpuGrant, .bankDmaGrant);
  srb_dma_model i_srb_dma_model (.go(dGo), .wr(dWr), .addr(dAddr),
    .dmaRef(dmaRef));

  //////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  // far beyond the few dozen cycles the tests need
  initial begin
    #100000;
    errorCnt++;
    tally_and_finish();
  end

  //////////////////////////////////////////////////////////////////////////
  // compare, access and verdict tasks
  task automatic chk(input logic [31:0] got, exp, input string m);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("Error %0t %s", $time, m);
    end
  endtask : chk
  // one write strobe, held across exactly one sampling edge
  task automatic wr(input logic dbg, input logic [11:0] rn,
                    input logic [31:0] d);
    @(negedge mclk);
    dbgWrEn = dbg;
    ctlWrEn = !dbg;
    ctlRegNum = rn;
    ctlWrData = d;
    dbgWrData = d;
    @(negedge mclk);
    dbgWrEn = 0;
    ctlWrEn = 0;
  endtask : wr
  // answer stands one cycle after the strobe
  task automatic rd(input logic [31:0] e, input string m);
    @(negedge mclk);
    dbgRdEn = 1;
    @(negedge mclk);
    dbgRdEn = 0;
    chk(dbgRdValid, 1, m);
    chk(dbgRdData, e, m);
  endtask : rd
  // decode is combinational, so sample once inputs settle
  task automatic acc(input logic w, input logic [31:0] a, input logic dg);
    @(negedge mclk);
    cpuRef = {1'b1, w, a};
    dGo = dg;
    dAddr = a;
    #1;
  endtask : acc
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  //////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    rst_b = 0;
    {ctlWrEn, dbgWrEn, dbgRdEn, dGo, dWr} = '0;
    peripheralBankEnable = 1;
    {ctlRegNum, ctlWrData, dbgWrData, dAddr} = '0;
    cpuRef = '0;
    cpuSpace = srb_pkg::SPACE_SUPER_DATA;
    repeat (10) @(negedge mclk);
    rst_b = 1;
    wr(1, 12'h000, 32'hFFFFFFFF);
    rd(32'hFFFF0F3F, "debug write");
    wr(0, 12'hC04, 32'h00000000);
    rd(32'hFFFF0F3F, "wrong number");
    wr(0, 12'hC05, 32'h80000001);
    rd(32'h80000001, "core move");
    $display("registers done");
    acc(0, 32'h80000010, 0);
    chk({cpuSel, bankCpuGrant}, 3'b101, "lower hit");
    acc(0, 32'h80004000, 0);
    chk({cpuSel, bankCpuGrant}, 3'b110, "upper hit");
    acc(0, 32'h80008000, 0);
    chk({cpuSel, bankCpuGrant}, 3'b000, "miss");
    // each space masked alone, a neighbour still served
    for (int s = 0; s < 5; s++) begin
      wr(1, 12'h000, 32'h80000001 | (32'h00000002 << s));
      cpuSpace = srb_pkg::srb_space_type'(3'(s));
      acc(0, 32'h80000010, 0);
      chk(cpuSel, 0, "masked");
      cpuSpace = srb_pkg::srb_space_type'(3'((s + 1) % 5));
      #1 chk(cpuSel, 1, "unmasked");
    end
    wr(1, 12'h000, 32'h80000101);
    acc(1, 32'h80000010, 0);
    chk({cpuAccessErr, cpuSel}, 2'b10, "wp write");
    acc(0, 32'h80000010, 0);
    chk({cpuAccessErr, cpuSel}, 2'b01, "wp read");
    $display("decode done");
    // codes above zero go against the advice on purpose
    for (int c = 0; c < 4; c++) begin
      wr(1, 12'h000, 32'h80000201 | (c << 10));
      acc(0, 32'h80004000, 1);
      chk({dmaSel, dmaStall, cpuStall, cpuSel, bankDmaGrant},
          {c[1], !c[1], c[1], !c[1], c[1], 1'b0}, "up");
      acc(0, 32'h80000000, 1);
      chk({dmaSel, dmaStall, cpuStall, cpuSel, bankDmaGrant},
          {c[0], !c[0], c[0], !c[0], 1'b0, c[0]}, "lo");
    end
    peripheralBankEnable = 0;
    #1 chk({dmaSel, cpuSel}, 2'b01, "bank enable off");
    peripheralBankEnable = 1;
    wr(1, 12'h000, 32'h80000C01);
    chk({dmaSel, cpuSel}, 2'b01, "port off");
    // dma write refused under write protect, then loses a cpu-first bank
    wr(1, 12'h000, 32'h80000301);
    dWr = 1;
    acc(0, 32'h80004000, 1);
    chk({dmaAccessErr, dmaSel, dmaStall, bankDmaGrant}, 5'b10000,
        "dma wp write");
    @(negedge mclk);
    dWr = 0;
    #1 chk({dmaAccessErr, dmaSel, dmaStall, bankDmaGrant}, 5'b00100,
        "dma stall");
    $display("priority done");
    rst_b = 0;
    #1 chk(cpuSel, 0, "in reset");
    @(negedge mclk);
    rst_b = 1;
    rd(32'h80000300, "after reset");
    chk(cpuSel, 0, "disabled");
    cpuRef = '0;
    dGo = 0;
    $display("reset done");
    tally_and_finish();
  end
endmodule : tb
